// ==== pkg/serial_link_test_pkg.sv ====
`default_nettype none
package serial_link_test_pkg;

  // ==========================================================================
  // Widths and constants
  localparam int          VID_W        = 24;
  localparam int          CNT_W        = 8;
  localparam logic [7:0]  CNT_MAX      = 8'hff;
  localparam logic [7:0]  CNT_ZERO     = 8'h00;
  localparam logic [23:0] TEST_PATTERN = 24'h000000;
  localparam logic [23:0] SCRAM_SEED   = 24'hace1f3;
  localparam logic [23:0] VID_RESET    = 24'h000000;
  localparam logic [4:0]  HALF_WORD    = 5'h0c;
  localparam logic [9:0]  RD_RESET     = 10'h000;

  // ==========================================================================
  // Carriers and states
  typedef struct packed {
    logic              de;
    logic [VID_W-1:0]  rgb;
  } video_word_type;

  typedef struct packed {
    logic              inv;
    logic              de;
    logic [VID_W-1:0]  payload;
  } link_word_type;

  typedef enum logic [0:0] {ST_NORMAL, ST_TEST} mode_type;

endpackage : serial_link_test_pkg
`default_nettype wire

// ==== design/serial_link_self_test.sv ====
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Receiver starts the test; enable arrives here over the back channel.
// - In test, video pins are ignored; all-zeros pattern sent at speed.
// - Test pattern is scrambled and DC-balanced exactly like video.
// - Test lasts while receiver enable is high; then normal operation.
// - Lock indication stays valid throughout test mode.
// - Back-channel CRC checked only after back-channel link detect.
// - 8-bit CRC error tally cleared on entering test mode.
// - Test-mode CRC count runs only in test; kept until clear/entry.
module serial_link_self_test
  import serial_link_test_pkg::*;
(
  input  wire logic           mclk_in,
  input  wire logic           rst_in,
  input  wire video_word_type video_in,
  input  wire logic           bc_test_enable_in,
  input  wire logic           bc_link_detect_in,
  input  wire logic           bc_crc_err_in,
  input  wire logic           link_lock_in,
  input  wire logic           test_crc_clear_in,
  output var link_word_type   link_word_out,
  output logic                lock_out,
  output logic                test_active_out,
  output logic [CNT_W-1:0]    crc_err_count_out,
  output logic [CNT_W-1:0]    test_crc_count_out
);

  // ==========================================================================
  // Helpers
  function automatic logic [23:0] lfsr_next(input logic [23:0] s);
    lfsr_next = {s[22:0], s[23] ^ s[22] ^ s[21] ^ s[16]};
  endfunction : lfsr_next

  function automatic logic [4:0] ones_count(input logic [23:0] w);
    logic [4:0] n;
    n = 5'h00;
    for (int i = 0; i < VID_W; i++) begin
      n = n + {4'h0, w[i]};
    end
    ones_count = n;
  endfunction : ones_count

  function automatic logic [7:0] sat_inc(input logic [7:0] c,
                                         input logic       ev);
    sat_inc = (ev && c != CNT_MAX) ? c + 8'h01 : c;
  endfunction : sat_inc

  // ==========================================================================
  // Mode control
  mode_type          mode_q;
  logic              test_entry;
  logic              crc_event;

  assign test_entry = (mode_q == ST_NORMAL) && bc_test_enable_in;
  assign crc_event  = bc_link_detect_in && bc_crc_err_in;

  // Mode follows the back-channel enable level
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      mode_q <= ST_NORMAL;
    end else begin
      case (mode_q)
        ST_NORMAL: if (bc_test_enable_in) mode_q <= ST_TEST;
        ST_TEST:   if (!bc_test_enable_in) mode_q <= ST_NORMAL;
        default:   mode_q <= ST_NORMAL;
      endcase
    end
  end

  assign test_active_out = (mode_q == ST_TEST);

  // ==========================================================================
  // Source select
  logic [VID_W-1:0]  sel_q;
  logic              sel_de_q;

  // Video pins are not sampled at all in test
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      sel_q    <= VID_RESET;
      sel_de_q <= 1'b0;
    end else if (mode_q == ST_TEST) begin
      sel_q    <= TEST_PATTERN;
      sel_de_q <= 1'b1;
    end else begin
      sel_q    <= video_in.rgb;
      sel_de_q <= video_in.de;
    end
  end

  // ==========================================================================
  // Scramble and DC balance, shared by both sources
  logic [23:0]       lfsr_q;
  logic [VID_W-1:0]  scr;
  logic [4:0]        scr_ones;
  logic              do_inv;
  logic [4:0]        out_ones;
  logic [9:0]        rd_q;
  link_word_type     link_q;

  assign scr      = sel_q ^ lfsr_q;
  assign scr_ones = ones_count(scr);
  // Invert when the word would push disparity further the same way
  assign do_inv   = rd_q[9] ? (scr_ones < HALF_WORD)
                            : (scr_ones > HALF_WORD);
  assign out_ones = do_inv ? (5'h18 - scr_ones) : scr_ones;

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      lfsr_q <= SCRAM_SEED;
    end else begin
      lfsr_q <= lfsr_next(lfsr_q);
    end
  end

  // Disparity stays within one word either side of zero
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      rd_q <= RD_RESET;
    end else begin
      rd_q <= rd_q + {4'h0, out_ones, 1'b0} - 10'h018;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      link_q <= '0;
    end else begin
      link_q.inv     <= do_inv;
      link_q.de      <= sel_de_q;
      link_q.payload <= do_inv ? ~scr : scr;
    end
  end

  assign link_word_out = link_q;

  // ==========================================================================
  // Lock indication
  logic              lock_q;

  // Frozen during test so the receiver never sees a lock drop
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      lock_q <= 1'b0;
    end else if (mode_q != ST_TEST) begin
      lock_q <= link_lock_in;
    end else begin
      lock_q <= lock_q;
    end
  end

  assign lock_out = lock_q;

  // ==========================================================================
  // Back-channel CRC error counters
  logic [CNT_W-1:0]  crc_cnt_q;
  logic [CNT_W-1:0]  test_cnt_q;

  // Entry clears, but an error in that cycle still counts
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      crc_cnt_q <= CNT_ZERO;
    end else if (test_entry) begin
      crc_cnt_q <= sat_inc(CNT_ZERO, crc_event);
    end else begin
      crc_cnt_q <= sat_inc(crc_cnt_q, crc_event);
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      test_cnt_q <= CNT_ZERO;
    end else if (test_entry) begin
      test_cnt_q <= CNT_ZERO;
    end else if (test_crc_clear_in) begin
      test_cnt_q <= sat_inc(CNT_ZERO, crc_event && mode_q == ST_TEST);
    end else begin
      test_cnt_q <= sat_inc(test_cnt_q,
                            crc_event && mode_q == ST_TEST);
    end
  end

  assign crc_err_count_out  = crc_cnt_q;
  assign test_crc_count_out = test_cnt_q;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (rst_in);

  a_pattern_subst: assert property (
    (mode_q == ST_TEST) |=> (sel_q == TEST_PATTERN && sel_de_q))
    else $error("test pattern not substituted");

  a_video_ignored: assert property (
    (mode_q == ST_TEST) ##1 (mode_q == ST_TEST) |=> $stable(sel_q))
    else $error("video sampled in test mode");

  a_scramble_path: assert property (
    1'b1 |=> ((link_q.payload ^ {VID_W{link_q.inv}})
              == ($past(sel_q) ^ $past(lfsr_q))))
    else $error("link word not from scrambled source");

  a_disparity_bound: assert property (
    ($signed(rd_q) <= 24) && ($signed(rd_q) >= -24))
    else $error("running disparity out of bounds");

  a_lock_held: assert property (
    (mode_q == ST_TEST) ##1 (mode_q == ST_TEST) |-> $stable(lock_out))
    else $error("lock changed during test");

  a_crc_gated: assert property (
    (!bc_link_detect_in && !test_entry) |=> $stable(crc_cnt_q))
    else $error("crc counted without link detect");

  a_crc_entry_clear: assert property (
    (test_entry && !crc_event) |=> (crc_cnt_q == CNT_ZERO)
                                   && (test_cnt_q == CNT_ZERO))
    else $error("counters not cleared on test entry");

  a_crc_count_up: assert property (
    (crc_event && !test_entry && crc_cnt_q != CNT_MAX)
      |=> (crc_cnt_q == $past(crc_cnt_q) + 8'h01))
    else $error("crc error not counted");

  a_test_cnt_idle: assert property (
    (mode_q == ST_NORMAL && !test_crc_clear_in && !test_entry)
      |=> $stable(test_cnt_q))
    else $error("test count moved outside test");

  a_crc_saturate: assert property (
    (crc_cnt_q == CNT_MAX && !test_entry) ##1 (crc_event && !test_entry)
      |=> (crc_cnt_q == CNT_MAX))
    else $error("crc count wrapped");

  c_test_run: cover property (
    test_entry ##1 (mode_q == ST_TEST)[*4] ##1 (mode_q == ST_NORMAL));
  c_test_errors: cover property (
    (mode_q == ST_TEST) && crc_event ##1 (test_cnt_q != CNT_ZERO));
  c_saturated: cover property (crc_cnt_q == CNT_MAX && crc_event);
  c_inverted: cover property (link_q.inv && mode_q == ST_TEST);

endmodule : serial_link_self_test
`default_nettype wire

// ==== tb/link_rx_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module link_rx_model
  import serial_link_test_pkg::*;
(
  input  wire logic           mclk_in,
  input  wire logic           rst_in,
  input  wire logic           test_run_pin_in,
  input  wire logic           lock_in,
  input  wire link_word_type  word_in,
  output logic                result_out,
  output logic [7:0]          err_frames_out
);
  logic [23:0] prev_q;
  logic [2:0]  warm_q;
  logic [23:0] seen;
  logic [23:0] step;

  // Zero source leaves bare scrambler state; phase-free check
  assign seen = word_in.payload ^ {24{word_in.inv}};
  assign step = {prev_q[22:0],
                 prev_q[23] ^ prev_q[22] ^ prev_q[21] ^ prev_q[16]};

  // ====
  // Pattern checking
  // Checks on the pixel clock; oscillator choice is the receiver's
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      result_out <= 1'b0;
      err_frames_out <= 8'h00;
      prev_q <= 24'h000000;
      warm_q <= 3'h0;
    end else if (test_run_pin_in && lock_in) begin
      prev_q <= seen;
      if (warm_q == 3'h0) begin
        result_out <= 1'b1;
        err_frames_out <= 8'h00;
      end
      // Skip words still in the pipeline from before the test
      if (warm_q != 3'h6) begin
        warm_q <= warm_q + 3'h1;
      end else if (!word_in.de || seen != step) begin
        err_frames_out <= err_frames_out + 8'h01;
        result_out <= 1'b0;
      end
    end else begin
      warm_q <= 3'h0;
    end
  end
endmodule : link_rx_model
`default_nettype wire

// ==== tb/test_serial_link_self_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_serial_link_self_test;
  import serial_link_test_pkg::*;
  typedef struct packed {
    logic [4:0] ctl;
    logic [7:0] cnt;
    logic [7:0] tcnt;
  } row_type;
  logic           mclk_in = 1'b0;
  logic           rst_in = 1'b1;
  video_word_type video_in = '{1'b1, 24'h123456};
  logic           en = 1'b0;
  logic           det = 1'b0;
  logic           crc = 1'b0;
  logic           lock = 1'b1;
  logic           clr = 1'b0;
  link_word_type  word;
  logic           lock_o;
  logic           act;
  logic [7:0]     cnt;
  logic [7:0]     tcnt;
  logic           result;
  logic [7:0]     rx_errs;
  int             err_total = 0;
  int             comparisons = 0;
  // {enable, detect, error, clear, active}, counts after one edge
  row_type rows [13] = '{
    '{5'h0c, 8'h01, 8'h00}, '{5'h04, 8'h01, 8'h00},
    '{5'h0c, 8'h02, 8'h00}, '{5'h1d, 8'h01, 8'h00},
    '{5'h1d, 8'h02, 8'h01}, '{5'h15, 8'h02, 8'h01},
    '{5'h1f, 8'h03, 8'h01}, '{5'h1b, 8'h03, 8'h00},
    '{5'h1d, 8'h04, 8'h01}, '{5'h08, 8'h04, 8'h01},
    '{5'h0c, 8'h05, 8'h01}, '{5'h19, 8'h00, 8'h00},
    '{5'h08, 8'h00, 8'h00}};

  always #10 mclk_in = ~mclk_in;
  // Busy video so any leak into the test stream shows
  always @(negedge mclk_in) video_in.rgb <= video_in.rgb + 24'h5a5a5b;

  serial_link_self_test uut (
    .mclk_in(mclk_in), .rst_in(rst_in), .video_in(video_in),
    .bc_test_enable_in(en), .bc_link_detect_in(det),
    .bc_crc_err_in(crc), .link_lock_in(lock), .test_crc_clear_in(clr),
    .link_word_out(word), .lock_out(lock_o), .test_active_out(act),
    .crc_err_count_out(cnt), .test_crc_count_out(tcnt));

  link_rx_model rx_model (
    .mclk_in(mclk_in), .rst_in(rst_in), .test_run_pin_in(en),
    .lock_in(lock_o), .word_in(word), .result_out(result),
    .err_frames_out(rx_errs));

  // ====
  // Helpers
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(negedge mclk_in);
  endtask : tick

  task automatic end_sim;
    $display("mismatches %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_sim

  // ====
  // Sequence
  initial begin
    tick(12);
    rst_in = 1'b0;
    for (int i = 0; i < 13; i++) begin
      {en, det, crc, clr} = rows[i].ctl[4:1];
      tick(1);
      check(cnt, rows[i].cnt);
      check(tcnt, rows[i].tcnt);
      check({7'h00, act}, {7'h00, rows[i].ctl[0]});
    end
    // Software's sequence-bit pulse has no port on this block
    {en, det, crc, clr} = 4'hc;
    tick(20);
    lock = 1'b0;
    tick(30);
    check({7'h00, lock_o}, 8'h01);
    check({7'h00, result}, 8'h01);
    en = 1'b0;
    tick(3);
    check({7'h00, lock_o}, 8'h00);
    check(rx_errs, 8'h00);
    check({7'h00, result}, 8'h01);
    lock = 1'b1;
    crc = 1'b1;
    tick(260);
    check(cnt, 8'hff);
    en = 1'b1;
    tick(260);
    check(tcnt, 8'hff);
    check(cnt, 8'hff);
    rst_in = 1'b1;
    tick(1);
    check({cnt | tcnt}, 8'h00);
    check({7'h00, act}, 8'h00);
    {en, crc} = 2'h0;
    rst_in = 1'b0;
    tick(2);
    check({7'h00, act}, 8'h00);
    end_sim();
  end
endmodule : test_serial_link_self_test
`default_nettype wire
